// ==== mf_irq_pkg.sv ====
// shared constants and types for the multi-function interrupt and wake-up logic
package mf_irq_pkg;
  localparam int          PC_W          = 13;
  localparam int          STACK_DEPTH   = 8;
  localparam int          SP_W          = 4;
  localparam logic [12:0] MF_VECTOR     = 13'h0010;
  localparam logic        GIE_RST       = 1'b0;
  localparam logic        FLAG_RST      = 1'b0;
  localparam logic        EN_RST        = 1'b0;
  localparam logic [3:0]  SP_RST        = 4'h0;
  localparam logic [12:0] PC_RST        = 13'h0000;
  typedef enum logic [1:0] {OP_NONE, OP_RETURN, OP_RETURN_REENABLE} ret_op_t;
  typedef enum {SEQ_RUN, SEQ_SLEEP} seq_state_t;
endpackage

// ==== mf_irq_if.sv ====
// interface joining the interrupt unit and the core's program sequencer
`timescale 1ns/1ps
interface mf_irq_if;
  import mf_irq_pkg::*;
  logic              irq_req;      // unit asks for a call to the shared vector
  logic              irq_ack;      // core takes the call this cycle
  logic              stack_full;   // core stack has no free level
  logic              global_irq_enable;
  logic              wakeup;       // wake pulse: one cycle, two when an enabled member also raises the group flag
  logic              low_power;    // core in the sleep state
  logic [1:0]        ret_op;       // return kind executed this cycle
  modport unit (output irq_req, output global_irq_enable, output wakeup,
                input irq_ack, input stack_full, input low_power, input ret_op);
  modport core (input irq_req, input global_irq_enable, input wakeup,
                output irq_ack, output stack_full, output low_power, output ret_op);
endinterface

// ==== mf_irq_unit.sv ====
// interrupt unit: low-voltage and nvm-done sources in one multi-function group
`timescale 1ns/1ps
module mf_irq_unit
  import mf_irq_pkg::*;
(
  input  wire logic sys_clk_i,
  input  wire logic reset_i,
  input  wire logic clk_en_i,
  input  wire logic low_voltage_detector_i,  // level: supply below threshold
  input  wire logic nvm_cycle_done_i,        // pulse: erase or write finished
  input  wire logic low_voltage_irq_enable_i,
  input  wire logic nvm_done_irq_enable_i,
  input  wire logic group_irq_enable_i,
  input  wire logic sw_clear_lv_i,           // pulse: software clears flag
  input  wire logic sw_clear_nvm_i,
  input  wire logic sw_set_lv_i,             // pulse: software presets flag
  input  wire logic sw_set_nvm_i,
  output logic      low_voltage_request_flag_o,
  output logic      nvm_done_request_flag_o,
  output logic      group_request_flag_o,
  mf_irq_if.unit    bus
);
  logic lv_r, nvm_r, grp_r, gie_r, req_r, wake_r;
  logic lv_prev_r, nvm_prev_r, grp_prev_r;
  logic lv_nxt, nvm_nxt, grp_nxt;
  logic take;

  // call accepted when the core acknowledges an offered request
  assign take = bus.irq_ack & req_r;

  // source flags: set wins over clear, service never touches them
  always_comb begin
    lv_nxt  = lv_r;
    nvm_nxt = nvm_r;
    if (sw_clear_lv_i)  lv_nxt = 1'b0;
    if (sw_clear_nvm_i) nvm_nxt = 1'b0;
    if (low_voltage_detector_i | sw_set_lv_i) lv_nxt = 1'b1;
    if (nvm_cycle_done_i | sw_set_nvm_i)       nvm_nxt = 1'b1;
  end

  // group flag: raised by any enabled pending member, cleared only by service
  always_comb begin
    grp_nxt = grp_r;
    if (take) grp_nxt = 1'b0;
    if ((lv_r & low_voltage_irq_enable_i) | (nvm_r & nvm_done_irq_enable_i))
      grp_nxt = 1'b1;
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      lv_r  <= FLAG_RST;
      nvm_r <= FLAG_RST;
      grp_r <= FLAG_RST;
    end else if (clk_en_i) begin
      lv_r  <= lv_nxt;
      nvm_r <= nvm_nxt;
      grp_r <= grp_nxt;
    end
  end

  // global enable: cleared on acceptance, set only by return-and-reenable
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      gie_r <= GIE_RST;
    end else if (clk_en_i) begin
      if (take) begin
        gie_r <= 1'b0;
      end else if (bus.ret_op == 2'(OP_RETURN_REENABLE)) begin
        gie_r <= 1'b1;
      end else if (bus.ret_op == 2'(OP_RETURN)) begin
        gie_r <= gie_r;
      end
      // a plain return leaves the enable as it stands
    end
  end

  // request offer: next group flag, group and global enables plus stack room; registered from the next
  // flag value, so the offer rises with the group flag and loses no cycle, yet stays glitch free
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      req_r <= 1'b0;
    end else if (clk_en_i) begin
      req_r <= grp_nxt & group_irq_enable_i & gie_r & ~take
               & ~bus.stack_full;
    end
  end

  // wake-up on any rising flag, enables deliberately ignored
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      lv_prev_r  <= FLAG_RST;
      nvm_prev_r <= FLAG_RST;
      grp_prev_r <= FLAG_RST;
      wake_r     <= 1'b0;
    end else if (clk_en_i) begin
      lv_prev_r  <= lv_r;
      nvm_prev_r <= nvm_r;
      grp_prev_r <= grp_r;
      wake_r     <= bus.low_power & ((lv_r & ~lv_prev_r) | (nvm_r & ~nvm_prev_r)
                    | (grp_r & ~grp_prev_r));
    end
  end

  assign low_voltage_request_flag_o = lv_r;
  assign nvm_done_request_flag_o    = nvm_r;
  assign group_request_flag_o       = grp_r;
  assign bus.irq_req                = req_r;
  assign bus.global_irq_enable      = gie_r;
  assign bus.wakeup                 = wake_r;
endmodule

// ==== mf_irq_core.sv ====
// program sequencer end: takes calls to the shared vector, pushes pc, returns
`timescale 1ns/1ps
module mf_irq_core
  import mf_irq_pkg::*;
(
  input  wire logic          sys_clk_i,
  input  wire logic          reset_i,
  input  wire logic          clk_en_i,
  input  wire logic          enter_sleep_i,   // pulse: halt instruction
  input  wire logic          exec_ret_i,      // pulse: plain return
  input  wire logic          exec_return_and_reenable_i,     // pulse: return and reenable
  output logic [PC_W-1:0]    pc_o,
  output logic [SP_W-1:0]    stack_level_o,
  output logic               sleeping_o,
  mf_irq_if.core             bus
);
  logic [PC_W-1:0] stack_r [STACK_DEPTH];
  logic [PC_W-1:0] pc_r;
  logic [SP_W-1:0] sp_r;
  logic            ack_r;
  logic [1:0]      op_r;
  seq_state_t      st_r;
  logic            full;
  logic            do_ret;

  assign full   = (sp_r == SP_W'(STACK_DEPTH));
  assign do_ret = (exec_ret_i | exec_return_and_reenable_i) & (sp_r != SP_RST) & (st_r == SEQ_RUN);

  // sequencer: only the program counter is saved on entry
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      pc_r  <= PC_RST;
      sp_r  <= SP_RST;
      ack_r <= 1'b0;
      op_r  <= 2'(OP_NONE);
      for (int i = 0; i < STACK_DEPTH; i++) stack_r[i] <= PC_RST;
    end else if (clk_en_i) begin
      ack_r <= 1'b0;
      op_r  <= 2'(OP_NONE);
      if (bus.irq_req & ~ack_r & ~full & (st_r == SEQ_RUN)) begin
        stack_r[sp_r[2:0]] <= pc_r;
        sp_r  <= sp_r + 4'h1;
        pc_r  <= MF_VECTOR;
        ack_r <= 1'b1;
      end else if (do_ret) begin
        pc_r <= stack_r[3'(sp_r - 4'h1)];
        sp_r <= sp_r - 4'h1;
        op_r <= exec_return_and_reenable_i ? 2'(OP_RETURN_REENABLE) : 2'(OP_RETURN);
      end else if (exec_return_and_reenable_i & (st_r == SEQ_RUN)) begin
        // empty stack: nothing to pop, but the enable is still raised, else
        // start-up code would have no way to open the interrupt path at all
        pc_r <= pc_r + 13'h0001;
        op_r <= 2'(OP_RETURN_REENABLE);
      end else if (st_r == SEQ_RUN) begin
        pc_r <= pc_r + 13'h0001;
      end
    end
  end

  // sleep state left on the unit's wake pulse
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      st_r <= SEQ_RUN;
    end else if (clk_en_i) begin
      case (st_r)
        SEQ_RUN:   if (enter_sleep_i) st_r <= SEQ_SLEEP;
        SEQ_SLEEP: if (bus.wakeup) st_r <= SEQ_RUN;
        default:   st_r <= SEQ_RUN;
      endcase
    end
  end

  assign bus.irq_ack    = ack_r;
  assign bus.stack_full = full;
  assign bus.low_power  = (st_r == SEQ_SLEEP);
  assign bus.ret_op     = op_r;
  assign pc_o           = pc_r;
  assign stack_level_o  = sp_r;
  assign sleeping_o     = (st_r == SEQ_SLEEP);
endmodule

// ==== mf_irq_checker.sv ====
// concurrent checks on the unit to core handshake
`timescale 1ns/1ps
module mf_irq_checker (
  input wire logic       sys_clk_i,
  input wire logic       reset_i,
  input wire logic       irq_req,
  input wire logic       irq_ack,
  input wire logic       stack_full,
  input wire logic       global_irq_enable,
  input wire logic       wakeup,
  input wire logic       low_power,
  input wire logic [1:0] ret_op
);
  // one domain, so clock and reset are given once
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  chk_call_needs_room: assert property (
    irq_ack |-> $past(irq_req && !stack_full)) else $error("call taken without room");
  chk_entry_clears_gie: assert property (
    irq_ack |=> !global_irq_enable) else $error("global enable kept after entry");
  chk_req_needs_gie: assert property (
    irq_req |-> global_irq_enable) else $error("request while globally disabled");
  chk_service_drops_req: assert property (
    irq_ack |=> !irq_req [*2]) else $error("request kept after service");
  chk_reenable_sets_gie: assert property (
    ret_op == 2'h2 |-> ##[0:1] global_irq_enable) else $error("reenable left gie low");
  chk_plain_ret_holds: assert property (
    ret_op == 2'h1 && !global_irq_enable |=> !global_irq_enable)
    else $error("plain return raised gie");
  chk_wake_in_sleep: assert property (
    wakeup |-> $past(low_power)) else $error("wake pulse while awake");
  chk_wake_ends_sleep: assert property (
    wakeup |-> ##[1:2] !low_power) else $error("core stayed asleep");
endmodule

// ==== tb_top.sv ====
// bench: unit and core joined by the interface, driven through pulse tasks
`timescale 1ns/1ps
module tb_top;
  import mf_irq_pkg::*;
  logic            sys_clk = 1'b0;
  logic            reset = 1'b1;
  logic [7:0]      pls = 8'h00; // sleep ret return_and_reenable set_lv clr_lv set_nvm clr_nvm nvm_done
  logic [2:0]      en = 3'h0;   // lv, nvm, group enables
  logic            low_voltage_detector = 1'b0;
  logic            clk_en = 1'b1;
  logic [PC_W-1:0] pc_hold;
  logic            lv_f, nvm_f, grp_f, slp;
  logic [PC_W-1:0] pc;
  logic [SP_W-1:0] lvl;
  int              fail_count = 0;
  int              n_tests = 0;
  mf_irq_if mf_bus ();
  mf_irq_unit mf_irq_unit_inst (.sys_clk_i(sys_clk), .reset_i(reset), .clk_en_i(clk_en),
    .low_voltage_detector_i(low_voltage_detector), .nvm_cycle_done_i(pls[0]), .low_voltage_irq_enable_i(en[2]),
    .nvm_done_irq_enable_i(en[1]), .group_irq_enable_i(en[0]), .sw_clear_lv_i(pls[3]),
    .sw_clear_nvm_i(pls[1]), .sw_set_lv_i(pls[4]), .sw_set_nvm_i(pls[2]),
    .low_voltage_request_flag_o(lv_f), .nvm_done_request_flag_o(nvm_f),
    .group_request_flag_o(grp_f), .bus(mf_bus));
  mf_irq_core mf_irq_core_inst (.sys_clk_i(sys_clk), .reset_i(reset), .clk_en_i(clk_en),
    .enter_sleep_i(pls[7]), .exec_ret_i(pls[6]), .exec_return_and_reenable_i(pls[5]), .pc_o(pc),
    .stack_level_o(lvl), .sleeping_o(slp), .bus(mf_bus));
  mf_irq_checker mf_irq_checker_inst (.sys_clk_i(sys_clk), .reset_i(reset),
    .irq_req(mf_bus.irq_req), .irq_ack(mf_bus.irq_ack), .stack_full(mf_bus.stack_full),
    .global_irq_enable(mf_bus.global_irq_enable), .wakeup(mf_bus.wakeup),
    .low_power(mf_bus.low_power), .ret_op(mf_bus.ret_op));
  initial begin
    forever #12.5 sys_clk = ~sys_clk;
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // one-cycle software or instruction strobe, lowered at the next edge
  task automatic pulse(input logic [7:0] p);
    @(posedge sys_clk);
    pls <= p;
    @(posedge sys_clk);
    pls <= 8'h00;
    #1;
  endtask
  // bounded wait: 0 request, 1 ack, 2 wake; caller checks the signal after
  task automatic wait_on(input int s);
    logic [2:0] v;
    for (int i = 0; i < 20; i++) begin
      step(1);
      v = {mf_bus.wakeup, mf_bus.irq_ack, mf_bus.irq_req};
      if (v[s] === 1'b1) break;
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // watchdog sized well past the under two hundred cycles the tests need
  initial begin
    repeat (3000) @(posedge sys_clk);
    fail_count++;
    finish_test();
  end
  initial begin
    repeat (12) @(posedge sys_clk);
    reset <= 1'b0;
    #1;
    check({lv_f, nvm_f, grp_f, mf_bus.global_irq_enable, lvl, pc}, 32'h0);
    $display("test reset done");
    pulse(8'h80);
    step(2);
    check(slp, 1'b1);
    low_voltage_detector <= 1'b1;
    wait_on(2);
    check(mf_bus.wakeup, 1'b1);
    check(lv_f, 1'b1);
    low_voltage_detector <= 1'b0;
    step(2);
    check(slp, 1'b0);
    $display("test wake done");
    pulse(8'h08);
    check(lv_f, 1'b0);
    pulse(8'h10);
    pulse(8'h80);
    step(2);
    low_voltage_detector <= 1'b1;
    step(6);
    check({slp, lv_f}, 2'h3);
    low_voltage_detector <= 1'b0;
    pulse(8'h01);
    wait_on(2);
    check({mf_bus.wakeup, nvm_f}, 2'h3);
    $display("test preset done");
    pulse(8'h22);
    step(2);
    check({mf_bus.global_irq_enable, lv_f, nvm_f}, 3'h6);
    en <= 3'b101;
    wait_on(0);
    check(mf_bus.irq_req, 1'b1);
    en <= 3'b001;
    step(1);
    check({mf_bus.irq_ack, pc, lvl}, {1'b1, MF_VECTOR, 4'h1});
    step(1);
    check({mf_bus.global_irq_enable, lv_f, grp_f}, 3'h2);
    pulse(8'h48);
    step(2);
    check({mf_bus.global_irq_enable, lvl, lv_f}, 6'h0);
    en <= 3'b011;
    pulse(8'h01);
    step(4);
    check({mf_bus.irq_req, nvm_f, grp_f}, 3'h3);
    pulse(8'h20);
    wait_on(0);
    en <= 3'b001;
    step(1);
    check({mf_bus.irq_ack, pc}, {1'b1, MF_VECTOR});
    pulse(8'h02);
    check(nvm_f, 1'b0);
    pulse(8'h20);
    step(2);
    check({mf_bus.global_irq_enable, lvl}, 5'h10);
    $display("test service done");
    // frozen clock enable: a flag strobe is lost and the pc stands still
    clk_en <= 1'b0;
    pc_hold = pc;
    pulse(8'h04);
    step(2);
    check({pc, nvm_f, mf_bus.global_irq_enable}, {pc_hold, 2'h1});
    clk_en <= 1'b1;
    $display("test freeze done");
    finish_test();
  end
endmodule
